// ===== lsla_pkg.sv
// constants and carrier types for the lmfc sync and latency alignment block
// assumes one processing clock domain; register port is byte wide
package lsla_pkg;
  // register addresses
  localparam logic [11:0] ADDR_IRQ_EN_A = 12'h021;
  localparam logic [11:0] ADDR_IRQ_EN_B = 12'h022;
  localparam logic [11:0] ADDR_IRQ_ST_A = 12'h025;
  localparam logic [11:0] ADDR_IRQ_ST_B = 12'h026;
  localparam logic [11:0] ADDR_SYNC_CTRL = 12'h03a;
  localparam logic [11:0] ADDR_SYNC_STAT = 12'h03b;
  localparam logic [11:0] ADDR_SUBCLASS = 12'h301;
  localparam logic [11:0] ADDR_LAT_0 = 12'h302;
  localparam logic [11:0] ADDR_LAT_1 = 12'h303;
  localparam logic [11:0] ADDR_DEL_A = 12'h304;
  localparam logic [11:0] ADDR_DEL_B = 12'h305;
  localparam logic [11:0] ADDR_VAR_A = 12'h306;
  localparam logic [11:0] ADDR_VAR_B = 12'h307;
  localparam logic [11:0] ADDR_LINK_SC = 12'h458;
  // field positions
  localparam int BIT_LOCK = 3;
  localparam int BIT_ROTA = 2;
  localparam int BIT_WLIM = 1;
  localparam int BIT_TRIP = 0;
  localparam int BIT_STICKY_CLR = 5;
  localparam int SC_MSB = 2;
  localparam int LINK_SC_MSB = 7;
  localparam int LINK_SC_LSB = 5;
  // values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [3:0] RBD_MAX = 4'ha;
  localparam logic [2:0] OCTETS_1 = 3'h1;
  localparam logic [2:0] OCTETS_2 = 3'h2;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic check;
    logic aligned;
    logic rotated;
    logic wlim;
  } lsla_sync_type;

  typedef struct packed {
    logic ilas_end;
    logic lanes_ready;
    logic link_error;
    logic sync_req;
  } lsla_link_type;

  typedef enum {
    LSLA_WAIT_ILAS,
    LSLA_WAIT_LMFC,
    LSLA_HOLD,
    LSLA_READ
  } lsla_state_type;
endpackage

// ===== lsla_link.sv
// one link: local lmfc, latency measurement and receive buffer release
// assumes global lmfc count and delays come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module lsla_link (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] gcnt_i,
  input wire logic [5:0] ppmf_i,
  input wire logic [5:0] delay_pc_i,
  input wire logic [3:0] var_i,
  input wire lsla_pkg::lsla_link_type link_i,
  output logic lmfc_o,
  output logic [7:0] latency_o,
  output logic read_o
);
  import lsla_pkg::*;

  logic [5:0] lcnt;
  logic [5:0] lat_cnt;
  logic [3:0] hold_cnt;
  logic local_edge;
  lsla_state_type state;

  // local lmfc trails the aligned one by the programmed delay
  always_comb begin
    if (gcnt_i >= delay_pc_i) begin
      lcnt = 6'(gcnt_i - delay_pc_i); // R14
    end else begin
      lcnt = 6'(gcnt_i + ppmf_i - delay_pc_i); // R14
    end
  end
  assign local_edge = (lcnt == 6'h00);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lmfc_o <= 1'b0;
    end else begin
      lmfc_o <= local_edge;
    end
  end

  // cycles since the local edge, caught at the end of alignment
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_cnt <= 6'h00;
      latency_o <= 8'h00;
    end else begin
      if (local_edge) begin
        lat_cnt <= 6'h01;
      end else if (lat_cnt != 6'h3f) begin
        lat_cnt <= 6'(lat_cnt + 6'h01);
      end
      if (link_i.ilas_end) begin
        latency_o <= local_edge ? 8'h00 : {2'h0, lat_cnt}; // R19
      end
    end
  end

  // release all lanes together once the buffer delay has run out
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= LSLA_WAIT_ILAS;
      hold_cnt <= 4'h0;
      read_o <= 1'b0;
    end else begin
      case (state)
        LSLA_WAIT_ILAS: begin
          read_o <= 1'b0;
          if (link_i.ilas_end) begin
            state <= LSLA_WAIT_LMFC;
          end
        end
        LSLA_WAIT_LMFC: begin
          if (local_edge) begin
            hold_cnt <= 4'h1;
            if (var_i == 4'h0 && link_i.lanes_ready) begin
              read_o <= 1'b1; // R15
              state <= LSLA_READ;
            end else begin
              state <= LSLA_HOLD;
            end
          end
        end
        LSLA_HOLD: begin
          if (hold_cnt >= var_i && link_i.lanes_ready) begin
            read_o <= 1'b1; // R13 R15
            state <= LSLA_READ;
          end else if (hold_cnt != 4'hf) begin
            hold_cnt <= 4'(hold_cnt + 4'h1);
          end
        end
        LSLA_READ: begin
          if (link_i.sync_req) begin
            read_o <= 1'b0;
            state <= LSLA_WAIT_ILAS;
          end
        end
        default: begin
          state <= LSLA_WAIT_ILAS;
          read_o <= 1'b0;
        end
      endcase
    end
  end

  lat_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (local_edge && link_i.ilas_end) |=> latency_o == 8'h00) // R19
    else $error("latency not zero at local edge");

  read_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(read_o) |-> $past(link_i.lanes_ready) &&
      ($past(hold_cnt) >= $past(var_i) || $past(var_i) == 4'h0)) // R15
    else $error("read released before buffer delay");
endmodule
`default_nettype wire

// ===== lsla_top.sv
// lmfc sync interrupt, subclass selection and deterministic latency top
// assumes ref_clk_i is the processing clock; sysref_i is an async pin
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1 - four sync status bits are maskable interrupt events
// R2 - pair a enables in 0x021 low nibble
// R3 - pair a status 0x025, write clears
// R4 - pair b enables in 0x022 low nibble
// R5 - pair b status 0x026, write clears
// R6 - only subclass 0 and 1 supported
// R7 - subclass 0 runs without sysref
// R8 - lanes share lmfc; both pairs synchronised
// R9 - transmitter always sends alignment sequence
// R10 - no error signalling in subclass 0, one octet
// R11 - subclass 1 aligns lmfc to sysref
// R12 - system latency variation at most ten cycles
// R13 - all lanes read in same lmfc period
// R14 - local lmfc delayed by programmable amount
// R15 - buffer delay 0 to 10 cycles
// R16 - frames per processing clock is 4/F
// R17 - software writes lmfc delay to both registers
// R18 - software writes variation delay to both registers
// R19 - report latency from local edge to data
// R20 - variation delay from max and min plus guard
// R21 - lmfc delay from min less one
// R22 - software unwraps latencies across multiframe
// R23 - lock updated on every phase check
// R24 - rotation sticky until sticky clear written
// R25 - interrupt while any enabled status latched
module lsla_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic sysref_i,
  input wire logic [2:0] octets_per_frame_i,
  input wire logic [5:0] frames_per_mf_i,
  input wire lsla_pkg::lsla_sync_type [1:0] sync_i,
  input wire lsla_pkg::lsla_link_type [1:0] link_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o,
  output logic [1:0] sync_req_n_o,
  output logic [1:0] lmfc_o,
  output logic [1:0] lane_read_o,
  output logic [1:0] pair_locked_o
);
  import lsla_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [1:0][3:0] irq_en;
  logic [1:0][3:0] irq_st;
  logic [1:0][3:0] flag;
  logic [1:0][7:0] lmfc_delay;
  logic [1:0][7:0] var_delay;
  logic [1:0][7:0] latency;
  logic [2:0] subclass;
  logic [7:0] link_sc;
  logic sticky_clr;
  logic [7:0] next_rdata;
  logic sc1;

  assign sc1 = (subclass == SUBCLASS_1) &&
    (link_sc[LINK_SC_MSB:LINK_SC_LSB] == SUBCLASS_1); // R6

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en <= '0;
      subclass <= 3'h0;
      link_sc <= REG_RESET;
      lmfc_delay <= '0;
      var_delay <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_IRQ_EN_A: irq_en[0] <= reg_wdata_i[3:0]; // R2
        ADDR_IRQ_EN_B: irq_en[1] <= reg_wdata_i[3:0]; // R4
        ADDR_SUBCLASS: subclass <= reg_wdata_i[SC_MSB:0]; // R6
        ADDR_LINK_SC: link_sc <= reg_wdata_i; // R6
        ADDR_DEL_A: lmfc_delay[0] <= reg_wdata_i;
        ADDR_DEL_B: lmfc_delay[1] <= reg_wdata_i;
        ADDR_VAR_A: var_delay[0] <= reg_wdata_i;
        ADDR_VAR_B: var_delay[1] <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // self clearing pulse for the sticky flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sticky_clr <= 1'b0;
    end else begin
      sticky_clr <= reg_wr_i && (reg_addr_i == ADDR_SYNC_CTRL) &&
        reg_wdata_i[BIT_STICKY_CLR]; // R24
    end
  end

  always_comb begin
    case (reg_addr_i)
      ADDR_IRQ_EN_A: next_rdata = {4'h0, irq_en[0]};
      ADDR_IRQ_EN_B: next_rdata = {4'h0, irq_en[1]};
      ADDR_IRQ_ST_A: next_rdata = {4'h0, irq_st[0]}; // R3
      ADDR_IRQ_ST_B: next_rdata = {4'h0, irq_st[1]}; // R5
      ADDR_SYNC_STAT: next_rdata = {flag[1], flag[0]};
      ADDR_SUBCLASS: next_rdata = {5'h00, subclass};
      ADDR_LAT_0: next_rdata = latency[0]; // R19
      ADDR_LAT_1: next_rdata = latency[1]; // R19
      ADDR_DEL_A: next_rdata = lmfc_delay[0];
      ADDR_DEL_B: next_rdata = lmfc_delay[1];
      ADDR_VAR_A: next_rdata = var_delay[0];
      ADDR_VAR_B: next_rdata = var_delay[1];
      ADDR_LINK_SC: next_rdata = link_sc;
      default: next_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= REG_RESET;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // sync status flags and interrupt events per converter pair
  // ----------------------------------------------------------------
  logic [1:0][3:0] event_set;
  logic [1:0][3:0] event_clr;

  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic [11:0] st_addr;
    assign st_addr = (p == 0) ? ADDR_IRQ_ST_A : ADDR_IRQ_ST_B;

    always_comb begin
      event_set[p] = 4'h0;
      event_set[p][BIT_LOCK] = sync_i[p].check && sync_i[p].aligned &&
        !flag[p][BIT_LOCK]; // R1
      event_set[p][BIT_ROTA] = sync_i[p].rotated; // R1
      event_set[p][BIT_WLIM] = sync_i[p].check && sync_i[p].wlim &&
        !flag[p][BIT_WLIM]; // R1
      event_set[p][BIT_TRIP] = sync_i[p].check; // R1
      event_clr[p] = (reg_wr_i && reg_addr_i == st_addr) ?
        reg_wdata_i[3:0] : 4'h0;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        flag[p] <= 4'h0;
      end else begin
        if (sync_i[p].check) begin
          flag[p][BIT_LOCK] <= sync_i[p].aligned; // R23
          flag[p][BIT_WLIM] <= sync_i[p].wlim;
        end
        if (sync_i[p].rotated) begin
          flag[p][BIT_ROTA] <= 1'b1; // R24
        end else if (sticky_clr) begin
          flag[p][BIT_ROTA] <= 1'b0; // R24
        end
        if (sync_i[p].check) begin
          flag[p][BIT_TRIP] <= 1'b1;
        end else if (sticky_clr) begin
          flag[p][BIT_TRIP] <= 1'b0;
        end
      end
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        irq_st[p] <= 4'h0;
      end else begin
        irq_st[p] <= (irq_st[p] & ~event_clr[p]) | event_set[p]; // R3 R5
      end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        pair_locked_o[p] <= 1'b0;
      end else begin
        pair_locked_o[p] <= flag[p][BIT_LOCK];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st & irq_en); // R2 R4 R25
    end
  end

  // ----------------------------------------------------------------
  // sysref capture and shared multiframe count
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sysref_sync;
  logic sysref_level;
  logic sysref_edge;
  logic [1:0] frame_shift;
  logic [5:0] ppmf;
  logic [5:0] gcnt;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sysref_sync <= '0;
      sysref_level <= 1'b0;
    end else begin
      sysref_sync <= {sysref_sync[SYNC_STAGES-2:0], sysref_i};
      if (sysref_sync[2] == sysref_sync[1]) begin
        sysref_level <= sysref_sync[2];
      end
    end
  end
  assign sysref_edge = sysref_sync[2] && sysref_sync[1] && !sysref_level;

  // frames per processing clock is 4/F, kept as a shift
  always_comb begin
    case (octets_per_frame_i)
      OCTETS_1: frame_shift = 2'h2; // R16
      OCTETS_2: frame_shift = 2'h1; // R16
      default: frame_shift = 2'h0; // R16
    endcase
  end
  assign ppmf = frames_per_mf_i >> frame_shift;

  // one count for both pairs keeps them in step
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gcnt <= 6'h00;
    end else if (sc1 && sysref_edge) begin
      gcnt <= 6'h00; // R11
    end else if (gcnt >= 6'(ppmf - 6'h01)) begin
      gcnt <= 6'h00; // R7 R8
    end else begin
      gcnt <= 6'(gcnt + 6'h01); // R7 R8
    end
  end

  // ----------------------------------------------------------------
  // links and sync request pins
  // ----------------------------------------------------------------
  logic err_allowed;
  assign err_allowed = sc1 || (octets_per_frame_i != OCTETS_1);

  for (genvar l = 0; l < 2; l++) begin : g_link
    logic [5:0] delay_pc;
    logic [3:0] var_clamped;
    assign delay_pc = 6'(lmfc_delay[l] >> frame_shift); // R16
    assign var_clamped = (var_delay[l] > {4'h0, RBD_MAX}) ?
      RBD_MAX : var_delay[l][3:0]; // R15

    lsla_link u_link (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .gcnt_i(gcnt),
      .ppmf_i(ppmf),
      .delay_pc_i(delay_pc),
      .var_i(var_clamped),
      .link_i(link_i[l]),
      .lmfc_o(lmfc_o[l]),
      .latency_o(latency[l]),
      .read_o(lane_read_o[l])
    );

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync_req_n_o[l] <= 1'b0;
      end else begin
        sync_req_n_o[l] <= !(link_i[l].sync_req ||
          (link_i[l].link_error && err_allowed)); // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_raise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (|(irq_st & irq_en)) |=> irq_o) // R25
    else $error("interrupt missing for pending event");

  irq_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(|(irq_st & irq_en)) |=> !irq_o) // R25
    else $error("interrupt with no pending event");

  trip_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sync_i[0].check |=> irq_st[0][BIT_TRIP] [*1]) // R1
    else $error("phase check not latched");

  status_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ADDR_IRQ_ST_B && reg_wdata_i[BIT_ROTA] &&
      !sync_i[1].rotated) |=> !irq_st[1][BIT_ROTA]) // R5
    else $error("status write did not clear");

  lock_update_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sync_i[0].check |=> flag[0][BIT_LOCK] == $past(sync_i[0].aligned)) // R23
    else $error("lock not updated on phase check");

  rota_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (flag[1][BIT_ROTA] && !sticky_clr) |=> flag[1][BIT_ROTA]) // R24
    else $error("rotation flag dropped without clear");

  no_err_sc0_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!sc1 && octets_per_frame_i == OCTETS_1 && !link_i[0].sync_req)
      |=> sync_req_n_o[0]) // R10
    else $error("error signalled in subclass 0 with one octet");

  sysref_align_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (sc1 && sysref_edge) |=> gcnt == 6'h00 ##1 gcnt == 6'h01 ||
      ppmf <= 6'h01) // R11
    else $error("multiframe count not aligned to sysref");

  free_run_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!sc1 && gcnt < 6'(ppmf - 6'h01) && $stable(ppmf))
      |=> gcnt == 6'($past(gcnt) + 6'h01)) // R7
    else $error("subclass 0 count disturbed");
endmodule
`default_nettype wire

// ===== lsla_far_end.sv
// far-end model: link transmitter and sysref source
// assumes lmfc_i is the device's registered local lmfc pulse
`timescale 1ns/10ps
`default_nettype none
module lsla_far_end (
  input wire logic ref_clk_i,
  input wire logic [1:0] lmfc_i,
  output var lsla_pkg::lsla_link_type [1:0] link_o,
  output logic sysref_o
);
  import lsla_pkg::*;
  initial begin
    link_o = '0;
    sysref_o = 1'b0;
  end
  // half duty periodic sysref, long enough to pass the pin filter
  always begin
    repeat (16) @(posedge ref_clk_i);
    #1 sysref_o = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1 sysref_o = 1'b0;
  end
  task automatic set_err(input int l, input logic v);
    @(posedge ref_clk_i);
    #1 link_o[l].link_error = v;
  endtask
  // resync, then alignment sequence ends k cycles after a local edge;
  // the registered lmfc pulse trails that edge by one cycle
  task automatic send_link(input int l, input int k, input int per);
    int n;
    @(posedge ref_clk_i);
    #1 link_o[l].sync_req = 1'b1;
    link_o[l].lanes_ready = 1'b0;
    @(posedge ref_clk_i);
    #1 link_o[l].sync_req = 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (lmfc_i[l] !== 1'b1 && n < 100);
    repeat (per + k - 1) @(posedge ref_clk_i);
    #1 link_o[l].ilas_end = 1'b1;
    @(posedge ref_clk_i);
    #1 link_o[l].ilas_end = 1'b0;
    link_o[l].lanes_ready = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== lsla_top_test.sv
// self-checking bench: registers, sync interrupts, link timing
// assumes lsla_far_end stands in for transmitter and sysref source
`timescale 1ns/10ps
`default_nettype none
module lsla_top_test;
  import lsla_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sysref_i;
  logic [2:0] octets_per_frame_i = 3'h4;
  logic [5:0] frames_per_mf_i = 6'h10;
  lsla_sync_type [1:0] sync_i = '0;
  lsla_link_type [1:0] link_i;
  logic [7:0] reg_rdata_o;
  logic irq_o;
  logic [1:0] sync_req_n_o, lmfc_o, lane_read_o, pair_locked_o;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] gap;
  logic [11:0] regs[10] = '{ADDR_IRQ_EN_A, ADDR_IRQ_EN_B, ADDR_IRQ_ST_A,
    ADDR_IRQ_ST_B, ADDR_SUBCLASS, ADDR_LAT_0, ADDR_DEL_A, ADDR_DEL_B,
    ADDR_VAR_A, 12'h123};
  int num_errors = 0;
  int n_checks = 0;
  int n, k;

  always #10 ref_clk_i = ~ref_clk_i;

  lsla_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .sysref_i(sysref_i),
    .octets_per_frame_i(octets_per_frame_i),
    .frames_per_mf_i(frames_per_mf_i), .sync_i(sync_i), .link_i(link_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .sync_req_n_o(sync_req_n_o), .lmfc_o(lmfc_o),
    .lane_read_o(lane_read_o), .pair_locked_o(pair_locked_o));

  lsla_far_end far (.ref_clk_i(ref_clk_i), .lmfc_i(lmfc_o),
    .link_o(link_i), .sysref_o(sysref_i));

  // ----------------------------
  // helpers
  // ----------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_wr_i = 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    #1 reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_rd_i = 1'b0;
  endtask
  task automatic sync_ev(input int p, input logic [3:0] s);
    @(posedge ref_clk_i);
    #1 sync_i[p] = s;
    @(posedge ref_clk_i);
    #1 sync_i[p].check = 1'b0;
    sync_i[p].rotated = 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge ref_clk_i);
    check("irq_o", {7'h0, irq_o}, {7'h0, e});
  endtask
  task automatic set_f(input logic [2:0] f);
    @(posedge ref_clk_i);
    #1 octets_per_frame_i = f;
  endtask
  task automatic req_is(input logic [7:0] e);
    repeat (3) @(negedge ref_clk_i);
    check("sync_req_n_o", {6'h0, sync_req_n_o}, e);
  endtask
  // counts cycles until the local edge or the read release shows
  task automatic wait_for(input bit lane, input int l, output int c);
    c = 0;
    do begin
      @(negedge ref_clk_i);
      c++;
    end while ((lane ? lane_read_o[l] : lmfc_o[l]) !== 1'b1 && c < 100);
  endtask

  always @(posedge ref_clk_i) rd_d <= reg_rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_d && exp_q.size() > 0) begin
      check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (6000) @(posedge ref_clk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    v = 8'($urandom(32'h4f35));
    repeat (2) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    foreach (regs[i]) rd_reg(regs[i], REG_RESET);
    for (int i = 0; i < 2; i++) begin
      v = 8'($urandom) & 8'h0f;
      wr_reg(ADDR_IRQ_EN_A + 12'(i), v);
      rd_reg(ADDR_IRQ_EN_A + 12'(i), v);
    end
    wr_reg(ADDR_LAT_0, 8'hff);
    rd_reg(ADDR_LAT_0, 8'h00);
    wr_reg(ADDR_IRQ_EN_A, 8'h09);
    wr_reg(ADDR_IRQ_EN_B, 8'h00);
    sync_ev(0, 4'b1100);
    irq_is(1'b1);
    check("pair_locked_o", {6'h0, pair_locked_o}, 8'h01);
    rd_reg(ADDR_IRQ_ST_A, 8'h09);
    wr_reg(ADDR_IRQ_ST_A, 8'h01);
    irq_is(1'b1);
    wr_reg(ADDR_IRQ_ST_A, 8'h08);
    irq_is(1'b0);
    sync_ev(1, 4'b0010);
    irq_is(1'b0);
    rd_reg(ADDR_IRQ_ST_B, 8'h04);
    wr_reg(ADDR_IRQ_EN_B, 8'h04);
    irq_is(1'b1);
    rd_reg(ADDR_SYNC_STAT, 8'h49);
    wr_reg(ADDR_SYNC_CTRL, 8'h20);
    rd_reg(ADDR_SYNC_STAT, 8'h08);
    wr_reg(ADDR_IRQ_ST_B, 8'h04);
    irq_is(1'b0);
    sync_ev(0, 4'b1001);
    irq_is(1'b1);
    check("pair_locked_o", {6'h0, pair_locked_o}, 8'h00);
    rd_reg(ADDR_IRQ_ST_A, 8'h03);
    // error reporting depends on subclass and octets per frame
    set_f(OCTETS_1);
    far.set_err(0, 1'b1);
    req_is(8'h03);
    set_f(OCTETS_2);
    req_is(8'h02);
    set_f(OCTETS_1);
    wr_reg(ADDR_SUBCLASS, 8'h01);
    wr_reg(ADDR_LINK_SC, 8'h20);
    req_is(8'h02);
    rd_reg(ADDR_SUBCLASS, 8'h01);
    far.set_err(0, 1'b0);
    // local edge spacing: 6 frames at two frames per cycle
    set_f(OCTETS_2);
    wr_reg(ADDR_DEL_B, 8'h06);
    rd_reg(ADDR_DEL_B, 8'h06);
    repeat (40) @(posedge ref_clk_i);
    wait_for(0, 0, n);
    wait_for(0, 0, n);
    check("lmfc period", 8'(n), 8'h08);
    wait_for(0, 1, n);
    check("lmfc lag", 8'(n), 8'h03);
    set_f(3'h4);
    wr_reg(ADDR_DEL_B, 8'h00);
    repeat (40) @(posedge ref_clk_i);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h0a : 8'h0c;
      wr_reg(ADDR_VAR_A + 12'(i % 2), v);
      k = (i == 0) ? 0 : int'($urandom % 15);
      far.send_link(i % 2, k, 16);
      @(posedge ref_clk_i);
      wait_for(0, i % 2, n);
      wait_for(1, i % 2, n);
      // read edge trails the lmfc pulse by the clamped delay; a zero delay still counts as one cycle
      gap = (v == 8'h00) ? 8'h01 : (v > 8'h0a) ? 8'h0a : v;
      check("read gap", 8'(n), gap);
      rd_reg(ADDR_LAT_0 + 12'(i % 2), 8'(k));
    end
    // setup from readbacks 13 and 2, the 2 wrapped past the multiframe edge
    n = 2 + 16;
    k = 13;
    v = 8'((n + 1) - (k - 1));
    wr_reg(ADDR_VAR_A, v);
    wr_reg(ADDR_VAR_B, v);
    rd_reg(ADDR_VAR_B, 8'h07);
    // one frame per processing clock at four octets, sixteen frames
    v = 8'(((k - 1) * 1) % 16);
    wr_reg(ADDR_DEL_A, v);
    wr_reg(ADDR_DEL_B, v);
    rd_reg(ADDR_DEL_A, 8'h0c);
    repeat (3) @(negedge ref_clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
